// ===== core/otwd_pkg.sv
// Constants shared by the hardware watchdog: key register address, key bytes,
// counter geometry and reset pulse timing.
// Assumes sys_clk is the oscillator clock itself, one oscillator period per edge.
package otwd_pkg;

  // Service key register on the special function register bus
  localparam logic [7:0]  WD_KEY_ADDR       = 8'ha6;
  localparam logic [7:0]  WD_KEY_FIRST      = 8'h1e;
  localparam logic [7:0]  WD_KEY_SECOND     = 8'he1;
  // Value returned on any read of the key register
  localparam logic [7:0]  WD_KEY_READ_VALUE = 8'h00;

  // Counter geometry and reset value
  localparam int          WD_CNT_WIDTH      = 14;
  localparam logic [13:0] WD_CNT_MAX        = 14'h3fff;
  localparam logic [13:0] WD_CNT_RESET      = 14'h0000;

  // Oscillator periods per machine cycle in each clock mode
  localparam logic [3:0]  MC_OSC_X6         = 4'h6;
  localparam logic [3:0]  MC_OSC_X12        = 4'hc;

  // Reset pulse length in oscillator periods for each clock mode
  localparam int          RST_PULSE_X6_OSC  = 98;
  localparam int          RST_PULSE_X12_OSC = 196;
  // Oscillator period and system clock period in ns
  localparam int          OSC_PERIOD_NS     = 100;
  localparam int          SYS_CLK_PERIOD_NS = 100;
  // Pulse lengths in sys_clk cycles (least time, rounded up)
  localparam int          RST_PULSE_X6_CYC  =
    (RST_PULSE_X6_OSC * OSC_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int          RST_PULSE_X12_CYC =
    (RST_PULSE_X12_OSC * OSC_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

  // Width of the pulse length down counter
  localparam int          PULSE_CNT_WIDTH   = 8;

endpackage : otwd_pkg

// ===== core/otwd_key_seq.sv
// Key sequence detector for the watchdog service register.
// Assumes writes arrive as one-cycle strobes on sys_clk with address and data valid.
`timescale 1ns/1ps
module otwd_key_seq
  import otwd_pkg::*;
(
  input  wire logic       sys_clk,     // Oscillator clock
  input  wire logic       reset,       // Synchronous, active high
  input  wire logic       clr,         // Holds the detector idle (reset pulse)
  input  wire logic       key_wr,      // Write strobe to the key register
  input  wire logic [7:0] key_wdata,   // Byte written
  output logic            key_done_ff  // One-cycle pulse: ordered pair seen
);

  logic armed_ff;  // First key byte was the last byte written here

  // Track the last byte; only the next write to this register can complete
  // the pair, so a stray first key is forgotten by any other value.
  always_ff @(posedge sys_clk) begin
    if (reset || clr) begin
      armed_ff <= 1'b0;
    end else if (key_wr) begin
      armed_ff <= (key_wdata == WD_KEY_FIRST);  // RULE13
    end
  end

  // Completion pulse on the second byte right after the first
  always_ff @(posedge sys_clk) begin
    if (reset || clr) begin
      key_done_ff <= 1'b0;
    end else begin
      key_done_ff <= key_wr && armed_ff && (key_wdata == WD_KEY_SECOND);  // RULE2
    end
  end

  // A completion only ever follows a first-key write then a second-key write
  AST_KEY_NEEDS_PAIR: assert property (  // RULE13
    @(posedge sys_clk) disable iff (reset)
    key_done_ff |-> $past(key_wr) && $past(key_wdata) == WD_KEY_SECOND && $past(armed_ff))
    else $error("key completion without ordered pair");

endmodule : otwd_key_seq

// ===== core/otwd_watchdog.sv
// One-time enabled hardware watchdog with reset-out drive.
// Assumes sys_clk is the oscillator, the register bus and mode select are
// synchronous to it, and the reset pin is joined by the surrounding pad logic.
//
// Functional notes
// [RULE1] Watchdog off and idle after any reset
// [RULE2] Enabled by 01EH then 0E1H at 0A6H
// [RULE3] Counter is fourteen bits wide
// [RULE4] Counts one per machine cycle while running
// [RULE5] Once on, only reset turns it off; here an overflow also clears wdt_enabled_ff
// [RULE6] Reaching 3FFFH is an overflow, resets device
// [RULE7] Key pair while enabled restarts counter at zero
// [RULE8] Firmware services within every 16383 machine cycles
// [RULE9] Overflow drives high pulse on reset pin
// [RULE10] Pulse 98 or 196 oscillator periods by mode
// [RULE11] Service register is write only, reads zero
// [RULE12] Counter neither readable nor loadable by software
// [RULE13] Lone first key or other byte does nothing
`timescale 1ns/1ps
module otwd_watchdog
  import otwd_pkg::*;
#(
  parameter int CNT_WIDTH = WD_CNT_WIDTH  // Counter width
)(
  input  wire logic       sys_clk,          // Oscillator clock, 10 MHz
  input  wire logic       reset,            // Hardware reset, sync, active high
  input  wire logic       six_clock_mode,   // High: 6-clock machine cycle
  input  wire logic [7:0] sfr_addr,         // Register bus address
  input  wire logic [7:0] sfr_wdata,        // Register bus write data
  input  wire logic       sfr_wr,           // Register bus write strobe
  input  wire logic       sfr_rd,           // Register bus read strobe
  output logic      [7:0] sfr_rdata_ff,     // Read data for the key address
  output logic            wdt_enabled_ff,   // Watchdog running
  output logic            wdt_sys_reset_ff, // Internal reset request
  output logic            rst_pin_o_ff,     // Reset pin drive level
  output logic            rst_pin_oe_ff     // Reset pin output enable
);

  // Address decode shared by read and write paths
  function automatic logic is_key_addr(input logic [7:0] addr);
    return addr == WD_KEY_ADDR;
  endfunction : is_key_addr

  logic [CNT_WIDTH-1:0]       cnt_ff;      // Machine cycle counter
  logic [CNT_WIDTH-1:0]       nxt_cnt;     // Next counter value
  logic [3:0]                 pre_ff;      // Oscillator periods in machine cycle
  logic                       mc_tick;     // Last period of a machine cycle
  logic                       key_done;    // Ordered key pair just completed
  logic                       overflow;    // Counter reached its top
  logic                       pulse_on;    // Reset pulse in progress
  logic [PULSE_CNT_WIDTH-1:0] pulse_cnt_ff;// Remaining pulse cycles
  logic                       pulse_x6_ff; // Mode captured for the pulse
  logic [3:0]                 mc_len;      // Machine cycle length now

  assign pulse_on = rst_pin_o_ff;
  assign mc_len   = six_clock_mode ? MC_OSC_X6 : MC_OSC_X12;
  // The top value itself is the overflow, only while enabled
  assign overflow = wdt_enabled_ff && (cnt_ff == CNT_WIDTH'(WD_CNT_MAX));  // RULE6

  // Key detector; held idle while the device sits in the overflow reset
  otwd_key_seq u_key_seq (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .clr         (pulse_on),
    .key_wr      (sfr_wr && is_key_addr(sfr_addr)),
    .key_wdata   (sfr_wdata),
    .key_done_ff (key_done)
  );

  // Machine cycle prescaler; the clamp keeps a mode switch from
  // leaving the count past the shorter length.
  always_ff @(posedge sys_clk) begin
    if (reset || !wdt_enabled_ff) begin
      pre_ff <= 4'h0;
    end else if (pre_ff >= mc_len - 4'h1) begin
      pre_ff <= 4'h0;
    end else begin
      pre_ff <= pre_ff + 4'h1;
    end
  end

  assign mc_tick = wdt_enabled_ff && (pre_ff >= mc_len - 4'h1);  // RULE4

  // Enable: set only by the key pair, cleared only by a reset or an overflow
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wdt_enabled_ff <= 1'b0;  // RULE1
    end else if (overflow) begin
      wdt_enabled_ff <= 1'b0;  // RULE5
    end else if (key_done) begin
      wdt_enabled_ff <= 1'b1;  // RULE2
    end
  end

  // Next counter value; overflow wins over a late service
  always_comb begin
    if (!wdt_enabled_ff || overflow) begin
      nxt_cnt = CNT_WIDTH'(WD_CNT_RESET);  // RULE1
    end else if (key_done) begin
      nxt_cnt = CNT_WIDTH'(WD_CNT_RESET);  // RULE7
    end else if (mc_tick) begin
      nxt_cnt = cnt_ff + CNT_WIDTH'(1);    // RULE4
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  // Counter register; no bus path reads or loads it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_ff <= CNT_WIDTH'(WD_CNT_RESET);
    end else begin
      cnt_ff <= nxt_cnt;  // RULE3 RULE12
    end
  end

  // Reset pulse: length fixed by the mode at the moment of overflow,
  // so a mode write during the pulse cannot stretch or cut it.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rst_pin_o_ff  <= 1'b0;
      rst_pin_oe_ff <= 1'b0;
      pulse_cnt_ff  <= '0;
      pulse_x6_ff   <= 1'b0;
    end else if (overflow) begin
      rst_pin_o_ff  <= 1'b1;  // RULE9
      rst_pin_oe_ff <= 1'b1;
      pulse_x6_ff   <= six_clock_mode;
      pulse_cnt_ff  <= six_clock_mode  // RULE10
        ? PULSE_CNT_WIDTH'(RST_PULSE_X6_CYC - 1)
        : PULSE_CNT_WIDTH'(RST_PULSE_X12_CYC - 1);
    end else if (pulse_on) begin
      if (pulse_cnt_ff == '0) begin
        rst_pin_o_ff  <= 1'b0;
        rst_pin_oe_ff <= 1'b0;
      end else begin
        pulse_cnt_ff  <= pulse_cnt_ff - PULSE_CNT_WIDTH'(1);
      end
    end
  end

  // Internal reset follows the pin pulse cycle for cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wdt_sys_reset_ff <= 1'b0;
    end else if (overflow) begin
      wdt_sys_reset_ff <= 1'b1;  // RULE6
    end else if (pulse_on && pulse_cnt_ff == '0) begin
      wdt_sys_reset_ff <= 1'b0;
    end
  end

  // Reads never expose watchdog state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sfr_rdata_ff <= WD_KEY_READ_VALUE;
    end else if (sfr_rd && is_key_addr(sfr_addr)) begin
      sfr_rdata_ff <= WD_KEY_READ_VALUE;  // RULE11
    end
  end

  // Helper: length of the current high pulse, for the pulse check
  logic [PULSE_CNT_WIDTH:0] hi_len_ff;
  always_ff @(posedge sys_clk) begin
    if (reset || !rst_pin_o_ff) begin
      hi_len_ff <= '0;
    end else begin
      hi_len_ff <= hi_len_ff + (PULSE_CNT_WIDTH+1)'(1);
    end
  end

  AST_OFF_AFTER_RESET: assert property (  // RULE1
    @(posedge sys_clk) reset |=> !wdt_enabled_ff && cnt_ff == '0 && !rst_pin_o_ff)
    else $error("watchdog not idle after reset");

  AST_HOLD_WHILE_OFF: assert property (  // RULE1
    @(posedge sys_clk) disable iff (reset)
    !wdt_enabled_ff |-> cnt_ff == '0)
    else $error("counter moved while disabled");

  AST_ENABLE_ON_KEY: assert property (  // RULE2
    @(posedge sys_clk) disable iff (reset)
    key_done && !overflow |=> wdt_enabled_ff)
    else $error("key pair did not enable");

  AST_STAY_ENABLED: assert property (  // RULE5
    @(posedge sys_clk) disable iff (reset)
    wdt_enabled_ff && !overflow |=> wdt_enabled_ff)
    else $error("watchdog turned off without reset");

  AST_COUNT_STEP: assert property (  // RULE4
    @(posedge sys_clk) disable iff (reset)
    mc_tick && !key_done && !overflow |=> cnt_ff == $past(cnt_ff) + CNT_WIDTH'(1))
    else $error("counter did not step on machine cycle");

  AST_TICK_SPACING: assert property (  // RULE4
    @(posedge sys_clk) disable iff (reset)
    mc_tick && wdt_enabled_ff |=> !mc_tick [*5])
    else $error("machine cycle shorter than six periods");

  AST_OVERFLOW_RESET: assert property (  // RULE6
    @(posedge sys_clk) disable iff (reset)
    wdt_enabled_ff && cnt_ff == CNT_WIDTH'(WD_CNT_MAX)
      |=> wdt_sys_reset_ff && !wdt_enabled_ff && cnt_ff == '0)
    else $error("overflow did not reset");

  AST_SERVICE_RESTART: assert property (  // RULE7
    @(posedge sys_clk) disable iff (reset)
    wdt_enabled_ff && key_done && !overflow |=> cnt_ff == '0)
    else $error("service did not restart counter");

  AST_PIN_DRIVEN: assert property (  // RULE9
    @(posedge sys_clk) disable iff (reset)
    rst_pin_o_ff |-> rst_pin_oe_ff && wdt_sys_reset_ff)
    else $error("reset pin high but not driven");

  AST_PULSE_LENGTH: assert property (  // RULE10
    @(posedge sys_clk) disable iff (reset)
    $fell(rst_pin_o_ff) |-> hi_len_ff == (pulse_x6_ff
      ? (PULSE_CNT_WIDTH+1)'(RST_PULSE_X6_CYC) : (PULSE_CNT_WIDTH+1)'(RST_PULSE_X12_CYC)))
    else $error("reset pulse length wrong");

  AST_READ_ZERO: assert property (  // RULE11
    @(posedge sys_clk) disable iff (reset)
    sfr_rd && is_key_addr(sfr_addr) |=> sfr_rdata_ff == WD_KEY_READ_VALUE)
    else $error("key register read returned state");

endmodule : otwd_watchdog

// ===== test/otwd_watchdog_tb_top.sv
// Self-checking bench for the one-time enabled hardware watchdog.
// Assumes sys_clk is the oscillator and the bench is the only register bus master.
`timescale 1ns/1ps
module otwd_watchdog_tb_top;
  import otwd_pkg::*;

  // Machine cycles to overflow, in sys_clk cycles for six-clock mode
  localparam int OVF_CYC = 16383 * 6;

  logic       sys_clk;          // Oscillator clock
  logic       reset;            // Hardware reset
  logic       six_clock_mode;   // Clock mode select
  logic [7:0] sfr_addr;         // Bus address
  logic [7:0] sfr_wdata;        // Bus write data
  logic       sfr_wr;           // Write strobe
  logic       sfr_rd;           // Read strobe
  logic [7:0] sfr_rdata_ff;     // Read data
  logic       wdt_enabled_ff;   // Watchdog running
  logic       wdt_sys_reset_ff; // Internal reset request
  logic       rst_pin_o_ff;     // Reset pin level
  logic       rst_pin_oe_ff;    // Reset pin enable
  int         err_total;        // Mismatches
  int         num_checks;       // Comparisons made

  otwd_watchdog dut_u (
    .sys_clk(sys_clk), .reset(reset), .six_clock_mode(six_clock_mode),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata_ff(sfr_rdata_ff), .wdt_enabled_ff(wdt_enabled_ff),
    .wdt_sys_reset_ff(wdt_sys_reset_ff), .rst_pin_o_ff(rst_pin_o_ff),
    .rst_pin_oe_ff(rst_pin_oe_ff));

  // 10 MHz oscillator
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Single-bit and byte comparisons
  task automatic chk1(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk1

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic close_out;
    $display("Counts: checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // One write strobe; the byte is scrambled afterwards so stale data never helps
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge sys_clk);
    sfr_wr    <= 1'b0;
    sfr_wdata <= ~d;
  endtask : wr

  // Read of the key address must reveal nothing
  task automatic rd_check;
    @(posedge sys_clk);
    sfr_addr <= WD_KEY_ADDR;
    sfr_rd   <= 1'b1;
    @(posedge sys_clk);
    sfr_rd   <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk8(sfr_rdata_ff, WD_KEY_READ_VALUE, "key read");
  endtask : rd_check

  // Enable shows one edge after the pair completes; four leaves margin
  task automatic chk_en(input logic exp);
    repeat (4) @(posedge sys_clk);
    #1;
    chk1(wdt_enabled_ff, exp, "enabled");
  endtask : chk_en

  // Hardware reset held three cycles; everything idle afterwards
  task automatic t_reset;
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chk1(wdt_enabled_ff | wdt_sys_reset_ff | rst_pin_o_ff | rst_pin_oe_ff, 1'b0, "idle");
    chk_en(1'b0);
    rd_check;
    $display("test reset done");
  endtask : t_reset

  // Broken, misaddressed and lone keys must not enable
  task automatic t_false_keys;
    wr(WD_KEY_ADDR, WD_KEY_FIRST);
    wr(WD_KEY_ADDR, 8'h55);
    wr(WD_KEY_ADDR, WD_KEY_SECOND);
    chk_en(1'b0);
    wr(8'ha5, WD_KEY_FIRST);
    wr(8'ha5, WD_KEY_SECOND);
    chk_en(1'b0);
    wr(WD_KEY_ADDR, WD_KEY_SECOND);
    chk_en(1'b0);
    $display("test false keys done");
  endtask : t_false_keys

  // Proper pair enables; later writes cannot turn it off
  task automatic t_enable;
    six_clock_mode <= 1'b0;
    wr(WD_KEY_ADDR, WD_KEY_FIRST);
    wr(WD_KEY_ADDR, WD_KEY_SECOND);
    chk_en(1'b1);
    wr(WD_KEY_ADDR, 8'h00);
    wr(WD_KEY_ADDR, 8'hff);
    wr(WD_KEY_ADDR, WD_KEY_FIRST);
    wr(WD_KEY_ADDR, 8'h55);
    chk_en(1'b1);
    rd_check;
    $display("test enable done");
  endtask : t_enable

  // Service early, then let it overflow; measure delay and pulse length
  task automatic t_overflow;
    int n;
    six_clock_mode <= 1'b1;
    repeat (1000) @(posedge sys_clk);
    // Service well inside the overflow period, as firmware must
    wr(WD_KEY_ADDR, WD_KEY_FIRST);
    wr(WD_KEY_ADDR, WD_KEY_SECOND);
    n = 0;
    while (wdt_sys_reset_ff !== 1'b1 && n < OVF_CYC + 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (wdt_sys_reset_ff !== 1'b1) begin
      err_total++;
      $display("BAD t=%0t no overflow seen", $time);
      close_out();
    end
    // Phase of the machine-cycle divider leaves a few cycles of slack
    chk1(n >= OVF_CYC - 8 && n <= OVF_CYC + 14, 1'b1, "overflow delay");
    chk1(rst_pin_o_ff & rst_pin_oe_ff, 1'b1, "pin pulse");
    chk1(wdt_enabled_ff, 1'b0, "enabled at overflow");
    n = 1;
    // A key pair written inside the pulse must be ignored
    for (int k = 0; k < 300; k++) begin
      @(posedge sys_clk);
      if (k == 3) begin
        sfr_addr  <= WD_KEY_ADDR;
        sfr_wdata <= WD_KEY_FIRST;
        sfr_wr    <= 1'b1;
      end
      if (k == 4) sfr_wdata <= WD_KEY_SECOND;
      if (k == 5) sfr_wr <= 1'b0;
      #1;
      if (rst_pin_o_ff !== 1'b1) break;
      n++;
    end
    // A pulse that never ends is a hang: count it and stop here
    if (rst_pin_o_ff !== 1'b0) begin
      err_total++;
      $display("BAD t=%0t reset pulse never ended", $time);
      close_out();
    end
    chk8(8'(n), 8'(RST_PULSE_X6_OSC), "pulse length");
    chk1(wdt_sys_reset_ff | rst_pin_oe_ff, 1'b0, "pulse end");
    chk_en(1'b0);
    $display("test overflow done");
  endtask : t_overflow

  // Hardware reset in mid-run disables a running watchdog
  task automatic t_mid_reset;
    wr(WD_KEY_ADDR, WD_KEY_FIRST);
    wr(WD_KEY_ADDR, WD_KEY_SECOND);
    chk_en(1'b1);
    t_reset;
    $display("test mid reset done");
  endtask : t_mid_reset

  // Main sequence
  initial begin
    err_total      = 0;
    num_checks     = 0;
    reset          = 1'b1;
    six_clock_mode = 1'b1;
    sfr_addr       = 8'h00;
    sfr_wdata      = 8'h00;
    sfr_wr         = 1'b0;
    sfr_rd         = 1'b0;
    t_reset;
    t_false_keys;
    t_enable;
    t_overflow;
    t_mid_reset;
    close_out();
  end

endmodule : otwd_watchdog_tb_top
